// File: wbl_bus_model.sv
// external bus memory that accepts drained buffer writes
`timescale 1ns/1ps
`default_nettype none
module wbl_bus_model (
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire wbl_pkg::wbl_word_t i_addr,
    input wire wbl_pkg::wbl_word_t i_data,
    input wire logic [3:0] i_be,
    input wire logic i_seq,
    output logic o_ready
);
    import wbl_pkg::*;
    // ----------------------------------------
    // beat log, in arrival order
    // ----------------------------------------
    wbl_word_t log_addr [0:63];
    wbl_word_t log_data [0:63];
    logic [3:0] log_be [0:63];
    logic log_seq [0:63];
    int count = 0;
    logic toggle = 1'h0;
    // slow mode answers every other cycle; stall holds ready low
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            log_addr[count] <= i_addr;
            log_data[count] <= i_data;
            log_be[count] <= i_be;
            log_seq[count] <= i_seq;
            count <= count + 1;
        end
        toggle <= !toggle;
        o_ready <= !i_stall && (!i_slow || toggle);
    end
endmodule
`default_nettype wire

// File: wbl_cfg.svh
// constants of the write buffer and lockdown block
`ifndef WBL_CFG_SVH
`define WBL_CFG_SVH
`define WBL_ADDR_ENTRIES 4
`define WBL_DATA_ENTRIES 8
`define WBL_GROUP_WORDS 3'h4
`define WBL_LINES 64
`define WBL_LAST_LINE 6'h3f
`define WBL_SEG_LSB 4
`define WBL_IDX_MSB 5
`define WBL_LOCK_BIT 27
`define WBL_CRN_CACHE_OP 4'h7
`define WBL_CRM_DRAIN 4'ha
`define WBL_OP2_DRAIN 3'h4
`define WBL_CRM_PREFETCH 4'hd
`define WBL_OP2_PREFETCH 3'h1
`define WBL_CRN_LOCK 4'h9
`define WBL_CRM_LOCK 4'h0
`define WBL_OP2_LOCK_D 3'h0
`define WBL_OP2_LOCK_I 3'h1
`endif

// File: wbl_lock.sv
// cache lockdown state, victim restriction and forced prefetch
`include "wbl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wbl_lock (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    wbl_lock_if.lk lk
);
    import wbl_pkg::*;

    // ----------------------------------------
    // victim step inside the unlocked range
    // ----------------------------------------
    function automatic wbl_line_t vic_step(input wbl_line_t v,
        input wbl_line_t idx);
        if (v >= `WBL_LAST_LINE || v < idx) begin
            return idx;
        end
        return v + 6'h1;
    endfunction

    logic d_lock_reg, d_lock_next, i_lock_reg, i_lock_next;
    wbl_line_t d_idx_reg, d_idx_next, i_idx_reg, i_idx_next;
    wbl_line_t d_vic_reg, d_vic_next, i_vic_reg, i_vic_next;
    logic pf_valid_reg, pf_valid_next;
    wbl_word_t pf_addr_reg, pf_addr_next;
    logic wr_d, wr_i, wr_pf;

    // ----------------------------------------
    // decode and next state
    // ----------------------------------------
    always_comb begin
        wr_d = lk.cp_wr && wbl_cp_hit(lk.crn, lk.crm, lk.op2,
            `WBL_CRN_LOCK, `WBL_CRM_LOCK, `WBL_OP2_LOCK_D);
        wr_i = lk.cp_wr && wbl_cp_hit(lk.crn, lk.crm, lk.op2,
            `WBL_CRN_LOCK, `WBL_CRM_LOCK, `WBL_OP2_LOCK_I);
        wr_pf = lk.cp_wr && wbl_cp_hit(lk.crn, lk.crm, lk.op2,
            `WBL_CRN_CACHE_OP, `WBL_CRM_PREFETCH, `WBL_OP2_PREFETCH);
        d_lock_next = d_lock_reg;
        d_idx_next = d_idx_reg;
        i_lock_next = i_lock_reg;
        i_idx_next = i_idx_reg;
        d_vic_next = d_vic_reg;
        i_vic_next = i_vic_reg;
        if (lk.dfill && !d_lock_reg) begin
            d_vic_next = vic_step(d_vic_reg, d_idx_reg);
        end
        if (lk.ifill && !i_lock_reg) begin
            i_vic_next = vic_step(i_vic_reg, i_idx_reg);
        end
        if (wr_d) begin
            d_lock_next = lk.cp_data[`WBL_LOCK_BIT];
            d_idx_next = lk.cp_data[`WBL_IDX_MSB:0];
            if (d_vic_next < lk.cp_data[`WBL_IDX_MSB:0]) begin
                d_vic_next = lk.cp_data[`WBL_IDX_MSB:0];
            end
        end
        if (wr_i) begin
            i_lock_next = lk.cp_data[`WBL_LOCK_BIT];
            i_idx_next = lk.cp_data[`WBL_IDX_MSB:0];
            if (i_vic_next < lk.cp_data[`WBL_IDX_MSB:0]) begin
                i_vic_next = lk.cp_data[`WBL_IDX_MSB:0];
            end
        end
        pf_valid_next = wr_pf;
        pf_addr_next = wr_pf ? lk.cp_data : pf_addr_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            d_lock_reg <= 1'b0;
            i_lock_reg <= 1'b0;
            d_idx_reg <= 6'h0;
            i_idx_reg <= 6'h0;
            d_vic_reg <= 6'h0;
            i_vic_reg <= 6'h0;
            pf_valid_reg <= 1'b0;
            pf_addr_reg <= 32'h0;
        end else if (i_ce) begin
            d_lock_reg <= d_lock_next;
            i_lock_reg <= i_lock_next;
            d_idx_reg <= d_idx_next;
            i_idx_reg <= i_idx_next;
            d_vic_reg <= d_vic_next;
            i_vic_reg <= i_vic_next;
            pf_valid_reg <= pf_valid_next;
            pf_addr_reg <= pf_addr_next;
        end
    end

    // one index serves all four segments, segment from 16-byte step
    assign lk.dline = d_lock_reg ? d_idx_reg : d_vic_reg;
    assign lk.dseg = lk.dfill_addr[`WBL_SEG_LSB+1:`WBL_SEG_LSB];
    assign lk.iline = i_lock_reg ? i_idx_reg : i_vic_reg;
    assign lk.pf_valid = pf_valid_reg;
    assign lk.pf_addr = pf_addr_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_victim_range;
        @(posedge i_clk) disable iff (i_srst)
        !d_lock_reg |-> (lk.dline >= d_idx_reg);
    endproperty
    a_victim_range: assert property (p_victim_range)
        else $error("data victim below lock index");

    property p_lock_fill;
        @(posedge i_clk) disable iff (i_srst)
        (lk.dfill && d_lock_reg) |->
            (lk.dline == d_idx_reg) && (lk.dseg == lk.dfill_addr[5:4]);
    endproperty
    a_lock_fill: assert property (p_lock_fill)
        else $error("locked fill not at lock index");

    property p_prefetch;
        @(posedge i_clk) disable iff (i_srst)
        (i_ce && wr_pf) |=> lk.pf_valid && (lk.pf_addr == $past(lk.cp_data));
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("prefetch pointer not driven");
endmodule
`default_nettype wire

// File: wbl_lock_if.sv
// carrier between buffer top and lockdown unit
`timescale 1ns/1ps
`default_nettype none
interface wbl_lock_if;
    logic cp_wr;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] cp_data;
    logic dfill;
    logic [31:0] dfill_addr;
    logic ifill;
    logic [5:0] dline;
    logic [1:0] dseg;
    logic [5:0] iline;
    logic pf_valid;
    logic [31:0] pf_addr;
    modport ctl (output cp_wr, crn, crm, op2, cp_data, dfill, dfill_addr,
        ifill, input dline, dseg, iline, pf_valid, pf_addr);
    modport lk (input cp_wr, crn, crm, op2, cp_data, dfill, dfill_addr,
        ifill, output dline, dseg, iline, pf_valid, pf_addr);
endinterface
`default_nettype wire

// File: wbl_pkg.sv
// types and shared decode for the write buffer and lockdown block
package wbl_pkg;
    typedef logic [31:0] wbl_word_t;
    typedef logic [5:0] wbl_line_t;
    typedef enum logic {HL_RUN, HL_DRAIN} wbl_hold_t;

    // coprocessor write target match
    function automatic logic wbl_cp_hit(input logic [3:0] crn,
        input logic [3:0] crm, input logic [2:0] op2,
        input logic [3:0] ecrn, input logic [3:0] ecrm,
        input logic [2:0] eop2);
        return (crn == ecrn) && (crm == ecrm) && (op2 == eop2);
    endfunction
endpackage

// File: wbl_top.sv
// write buffer allocation and drain with cache lockdown control
// What this block does
// - no buffer switch; unbuffered regions bypass buffer
// - writes never merge; each gets own entry
// - same-word sub-word stores use two entries
// - store_multiple splits at 4-word boundaries
// - stall core while no address entry free
// - evicted dirty line uses one entry
// - hold execution until buffer empties when asked
// - four segments of 64 four-word lines
// - lock one index across all segments
// - lock from index zero, at most 63
// - lock via register 9, prefetch via 7
// - locked load miss fills at lock index
// - prefetch drives pointer and forces fetch
// - victim limited to index N through 63
// - eight data words, four address entries
// - reset discards all pending entries
`include "wbl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wbl_top #(
    parameter int NA = `WBL_ADDR_ENTRIES,
    parameter int ND = `WBL_DATA_ENTRIES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_pu_enable,
    input wire logic i_dcache_enable,
    input wire logic i_region_cachable,
    input wire logic i_region_bufferable,
    input wire logic i_st_valid,
    input wire logic i_st_new,
    input wire logic i_st_last,
    input wire logic i_st_multiple,
    input wire logic i_st_evict,
    input wire wbl_pkg::wbl_word_t i_st_addr,
    input wire wbl_pkg::wbl_word_t i_st_data,
    input wire logic [3:0] i_st_be,
    output logic o_st_ready,
    input wire logic i_nc_load,
    output logic o_core_stall,
    input wire logic i_cp_wr,
    input wire logic [3:0] i_cp_crn,
    input wire logic [3:0] i_cp_crm,
    input wire logic [2:0] i_cp_op2,
    input wire wbl_pkg::wbl_word_t i_cp_data,
    output logic o_bus_valid,
    input wire logic i_bus_ready,
    output wbl_pkg::wbl_word_t o_bus_addr,
    output wbl_pkg::wbl_word_t o_bus_data,
    output logic [3:0] o_bus_be,
    output logic o_bus_seq,
    output logic o_buf_empty,
    input wire logic i_dfill_req,
    input wire wbl_pkg::wbl_word_t i_dfill_addr,
    output wbl_pkg::wbl_line_t o_dfill_line,
    output logic [1:0] o_dfill_seg,
    input wire logic i_ifill_req,
    output wbl_pkg::wbl_line_t o_ifill_line,
    output logic o_ifetch_valid,
    output wbl_pkg::wbl_word_t o_ifetch_addr
);
    import wbl_pkg::*;
    localparam int AW = $clog2(NA);
    localparam int DW = $clog2(ND);

    wbl_word_t a_addr_reg [NA];
    wbl_word_t a_addr_next [NA];
    logic [2:0] a_len_reg [NA];
    logic [2:0] a_len_next [NA];
    wbl_word_t d_data_reg [ND];
    wbl_word_t d_data_next [ND];
    logic [3:0] d_be_reg [ND];
    logic [3:0] d_be_next [ND];
    logic [AW-1:0] aw_reg, aw_next, ar_reg, ar_next, a_open;
    logic [AW:0] acnt_reg, acnt_next;
    logic [DW-1:0] dw_reg, dw_next, dr_reg, dr_next;
    logic [DW:0] dcnt_reg, dcnt_next;
    logic [1:0] beat_reg, beat_next;
    logic open_reg, open_next;
    wbl_hold_t hold_reg, hold_next;
    logic buffered, need_alloc, a_free, d_free, accept, alloc;
    logic fire, release_a, drain_op, empty;

    // ----------------------------------------
    // store acceptance
    // ----------------------------------------
    always_comb begin
        buffered = i_pu_enable && ((i_region_cachable && i_dcache_enable)
            || i_region_bufferable);
        a_open = aw_reg - 1'b1;
        // new store, burst group start or full group opens entry
        need_alloc = i_st_new || !open_reg ||
            (i_st_multiple && !i_st_evict &&
             i_st_addr[3:2] == 2'b00) ||
            (a_len_reg[a_open] == `WBL_GROUP_WORDS);
        a_free = acnt_reg < (AW+1)'(NA);
        d_free = dcnt_reg < (DW+1)'(ND);
        empty = (acnt_reg == '0);
        o_st_ready = buffered ?
            ((!need_alloc || a_free) && d_free && hold_reg == HL_RUN) :
            (empty && hold_reg == HL_RUN);
        accept = i_ce && i_st_valid && buffered && o_st_ready;
        alloc = accept && need_alloc;
        drain_op = i_cp_wr && wbl_cp_hit(i_cp_crn, i_cp_crm, i_cp_op2,
            `WBL_CRN_CACHE_OP, `WBL_CRM_DRAIN, `WBL_OP2_DRAIN);
    end

    // ----------------------------------------
    // drain side, head entry only once closed
    // ----------------------------------------
    always_comb begin
        o_bus_valid = !empty &&
            !(open_reg && acnt_reg == (AW+1)'(1));
        o_bus_addr = a_addr_reg[ar_reg] + {28'h0, beat_reg, 2'b00};
        o_bus_data = d_data_reg[dr_reg];
        o_bus_be = d_be_reg[dr_reg];
        o_bus_seq = (beat_reg != 2'b00);
        fire = i_ce && o_bus_valid && i_bus_ready;
        release_a = fire && ({1'b0, beat_reg} + 3'h1 == a_len_reg[ar_reg]);
        o_buf_empty = empty;
        o_core_stall = (hold_reg == HL_DRAIN) || drain_op ||
            (i_nc_load && !empty) || (i_st_valid && !o_st_ready);
    end

    // ----------------------------------------
    // next state of the buffer
    // ----------------------------------------
    always_comb begin
        a_addr_next = a_addr_reg;
        a_len_next = a_len_reg;
        d_data_next = d_data_reg;
        d_be_next = d_be_reg;
        aw_next = aw_reg;
        dw_next = dw_reg;
        open_next = open_reg;
        if (accept) begin
            d_data_next[dw_reg] = i_st_data;
            d_be_next[dw_reg] = i_st_be;
            dw_next = dw_reg + 1'b1;
            open_next = !i_st_last;
            if (alloc) begin
                a_addr_next[aw_reg] = i_st_addr;
                a_len_next[aw_reg] = 3'h1;
                aw_next = aw_reg + 1'b1;
            end else begin
                a_len_next[a_open] = a_len_reg[a_open] + 3'h1;
            end
        end
        dr_next = fire ? dr_reg + 1'b1 : dr_reg;
        ar_next = release_a ? ar_reg + 1'b1 : ar_reg;
        beat_next = release_a ? 2'b00 : (fire ? beat_reg + 2'b01 : beat_reg);
        acnt_next = acnt_reg + (AW+1)'(alloc) - (AW+1)'(release_a);
        dcnt_next = dcnt_reg + (DW+1)'(accept) - (DW+1)'(fire);
        case (hold_reg)
            HL_RUN: hold_next = drain_op ? HL_DRAIN : HL_RUN;
            HL_DRAIN: hold_next = empty ? HL_RUN : HL_DRAIN;
            default: hold_next = HL_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            a_addr_reg <= a_addr_next;
            a_len_reg <= a_len_next;
            d_data_reg <= d_data_next;
            d_be_reg <= d_be_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_reg <= '0;
            ar_reg <= '0;
            acnt_reg <= '0;
            dw_reg <= '0;
            dr_reg <= '0;
            dcnt_reg <= '0;
            beat_reg <= 2'b00;
            open_reg <= 1'b0;
            hold_reg <= HL_RUN;
        end else if (i_ce) begin
            aw_reg <= aw_next;
            ar_reg <= ar_next;
            acnt_reg <= acnt_next;
            dw_reg <= dw_next;
            dr_reg <= dr_next;
            dcnt_reg <= dcnt_next;
            beat_reg <= beat_next;
            open_reg <= open_next;
            hold_reg <= hold_next;
        end
    end

    // ----------------------------------------
    // lockdown unit
    // ----------------------------------------
    wbl_lock_if lk_if ();
    assign lk_if.cp_wr = i_cp_wr;
    assign lk_if.crn = i_cp_crn;
    assign lk_if.crm = i_cp_crm;
    assign lk_if.op2 = i_cp_op2;
    assign lk_if.cp_data = i_cp_data;
    assign lk_if.dfill = i_dfill_req;
    assign lk_if.dfill_addr = i_dfill_addr;
    assign lk_if.ifill = i_ifill_req;
    assign o_dfill_line = lk_if.dline;
    assign o_dfill_seg = lk_if.dseg;
    assign o_ifill_line = lk_if.iline;
    assign o_ifetch_valid = lk_if.pf_valid;
    assign o_ifetch_addr = lk_if.pf_addr;

    wbl_lock u_lock (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .lk(lk_if.lk)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_uncached_unbuffered_bypass;
        @(posedge i_clk) disable iff (i_srst)
        (i_st_valid && !buffered) |-> !accept;
    endproperty
    a_uncached_unbuffered_bypass: assert property (p_uncached_unbuffered_bypass)
        else $error("unbuffered store entered buffer");

    property p_new_entry;
        @(posedge i_clk) disable iff (i_srst)
        (accept && i_st_new) |=> a_addr_reg[$past(aw_reg)] == $past(i_st_addr)
            && a_len_reg[$past(aw_reg)] == 3'h1;
    endproperty
    a_new_entry: assert property (p_new_entry)
        else $error("new store did not open its own entry");

    property p_data_entry;
        @(posedge i_clk) disable iff (i_srst)
        (accept && !fire) |=> dcnt_reg == $past(dcnt_reg) + 1'b1;
    endproperty
    a_data_entry: assert property (p_data_entry)
        else $error("store did not take a data entry");

    property p_split;
        @(posedge i_clk) disable iff (i_srst)
        (accept && i_st_multiple && !i_st_evict && i_st_addr[3:2] == 2'b00)
            |-> alloc;
    endproperty
    a_split: assert property (p_split)
        else $error("burst not split at group boundary");

    property p_full_stall;
        @(posedge i_clk) disable iff (i_srst)
        (i_st_valid && buffered && need_alloc && acnt_reg == (AW+1)'(NA))
            |-> o_core_stall && !accept;
    endproperty
    a_full_stall: assert property (p_full_stall)
        else $error("store accepted with no address entry");

    property p_evict_one;
        @(posedge i_clk) disable iff (i_srst)
        (accept && i_st_evict && !i_st_new && open_reg &&
         a_len_reg[a_open] < `WBL_GROUP_WORDS) |-> !alloc;
    endproperty
    a_evict_one: assert property (p_evict_one)
        else $error("eviction used a second entry");

    property p_drain_hold;
        @(posedge i_clk) disable iff (i_srst)
        (hold_reg == HL_DRAIN && !empty) |-> o_core_stall ##1 o_core_stall;
    endproperty
    a_drain_hold: assert property (p_drain_hold)
        else $error("core released before buffer empty");

    property p_capacity;
        @(posedge i_clk) disable iff (i_srst)
        acnt_reg <= (AW+1)'(NA) && dcnt_reg <= (DW+1)'(ND);
    endproperty
    a_capacity: assert property (p_capacity)
        else $error("buffer over capacity");

    property p_flush;
        @(posedge i_clk)
        i_srst |=> empty && !o_bus_valid;
    endproperty
    a_flush: assert property (p_flush)
        else $error("reset left entries pending");

    property p_order;
        @(posedge i_clk) disable iff (i_srst)
        release_a |=> ar_reg == $past(ar_reg) + 1'b1 && beat_reg == 2'b00;
    endproperty
    a_order: assert property (p_order)
        else $error("drain left write order");
endmodule
`default_nettype wire

// File: wbl_top_tb.sv
// self-checking bench for the write buffer and lockdown block
`timescale 1ns/1ps
`default_nettype none
module wbl_top_tb;
    import wbl_pkg::*;
    logic clk = '0, srst = '1, ce = '1, pu = '1, dce = '1, cach = '0;
    logic buff = '1, st_v = '0, st_n = '0, st_l = '0, st_m = '0, st_e = '0;
    logic nc = '0, cp_w = '0, df_r = '0, if_r = '0, hold = '0, slow = '0;
    wbl_word_t st_a = '0, st_d = '0, cp_d = '0, df_a = '0;
    logic [3:0] st_be = 4'hf, crn = '0, crm = '0;
    logic [2:0] op2 = '0;
    logic st_rdy, stall_c, bv, br, bseq, bempty, ifv;
    wbl_word_t ba, bd, ifa;
    logic [3:0] bbe;
    wbl_line_t dline, iline;
    logic [1:0] dseg;
    int failures = 0;
    int compares = 0;
    always #5 clk = ~clk;
    wbl_top dut (.i_clk(clk), .i_srst(srst), .i_ce(ce), .i_pu_enable(pu),
        .i_dcache_enable(dce), .i_region_cachable(cach),
        .i_region_bufferable(buff), .i_st_valid(st_v), .i_st_new(st_n),
        .i_st_last(st_l), .i_st_multiple(st_m), .i_st_evict(st_e),
        .i_st_addr(st_a), .i_st_data(st_d), .i_st_be(st_be),
        .o_st_ready(st_rdy), .i_nc_load(nc), .o_core_stall(stall_c),
        .i_cp_wr(cp_w), .i_cp_crn(crn), .i_cp_crm(crm), .i_cp_op2(op2),
        .i_cp_data(cp_d), .o_bus_valid(bv), .i_bus_ready(br),
        .o_bus_addr(ba), .o_bus_data(bd), .o_bus_be(bbe), .o_bus_seq(bseq),
        .o_buf_empty(bempty), .i_dfill_req(df_r), .i_dfill_addr(df_a),
        .o_dfill_line(dline), .o_dfill_seg(dseg), .i_ifill_req(if_r),
        .o_ifill_line(iline), .o_ifetch_valid(ifv), .o_ifetch_addr(ifa));
    wbl_bus_model bus (.i_clk(clk), .i_stall(hold), .i_slow(slow),
        .i_valid(bv), .i_addr(ba), .i_data(bd), .i_be(bbe), .i_seq(bseq),
        .o_ready(br));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
        end_of_test();
    endtask
    task automatic beat(input logic [31:0] a, input logic [3:0] be,
            input logic [3:0] f);
        int n;
        n = 0;
        @(negedge clk);
        st_v = '1;
        st_a = a;
        st_d = ~a;
        st_be = be;
        {st_n, st_l, st_m, st_e} = f;
        #1;
        while (st_rdy !== 1'b1) begin
            n++;
            if (n > 300) timeout();
            @(negedge clk);
            #1;
        end
        @(posedge clk);
    endtask
    task automatic idle;
        @(negedge clk);
        st_v = '0;
    endtask
    task automatic stuck(input logic [31:0] a, input logic [3:0] f);
        fork
            beat(a, 4'hf, f);
            begin
                repeat (3) @(negedge clk);
                #2;
                chk(st_rdy, 0);
                chk(stall_c, 1);
                hold = '0;
            end
        join
    endtask
    task automatic wait_empty;
        int n;
        n = 0;
        while (bempty !== 1'b1) begin
            n++;
            if (n > 300) timeout();
            @(negedge clk);
        end
        repeat (2) @(negedge clk);
    endtask
    task automatic cp(input logic [3:0] n, input logic [3:0] m,
            input logic [2:0] o, input logic [31:0] d);
        @(negedge clk);
        {cp_w, crn, crm, op2, cp_d} = {1'b1, n, m, o, d};
        @(negedge clk);
        cp_w = '0;
        #1;
    endtask
    task automatic fill(input logic [31:0] a, input int lo, input int hi);
        @(negedge clk);
        df_r = '1;
        df_a = a;
        #1;
        chk(dseg, a[5:4]);
        chk(dline >= lo && dline <= hi, 1);
        @(negedge clk);
        df_r = '0;
    endtask
    task automatic got(input int i, input logic [31:0] a, input logic s);
        chk(bus.log_addr[i], a);
        chk(bus.log_data[i], ~a);
        chk(bus.log_seq[i], s);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        int b;
        b = bus.count;
        chk(bempty, 1);
        chk(bv, 0);
        chk(st_rdy, 1);
        hold = '1;
        beat(32'h80, 4'hf, 4'hc);
        idle();
        @(negedge clk);
        srst = '1;
        @(negedge clk);
        srst = '0;
        #1;
        chk(bempty, 1);
        hold = '0;
        repeat (4) @(negedge clk);
        chk(bus.count - b, 0);
        $display("reset test done");
    endtask
    task automatic t_stm;
        int b;
        logic [31:0] a;
        b = bus.count;
        hold = '1;
        for (int i = 0; i < 6; i++)
            beat(32'h10c + 4 * i, 4'hf, {i == 0, i == 5, 2'h2});
        beat(32'h20c, 4'hf, 4'ha);
        stuck(32'h210, 4'h2);
        beat(32'h214, 4'hf, 4'h2);
        beat(32'h218, 4'hf, 4'h2);
        beat(32'h21c, 4'hf, 4'h6);
        idle();
        wait_empty();
        for (int i = 0; i < 11; i++) begin
            a = i < 6 ? 32'h10c + 4 * i : 32'h1f4 + 4 * i;
            got(b + i, a, i != 0 && i != 6 && a[3:2] != 0);
        end
        chk(bus.count - b, 11);
        $display("store multiple test done");
    endtask
    task automatic t_merge;
        int b;
        b = bus.count;
        slow = '1;
        beat(32'h40, 4'h1, 4'hc);
        beat(32'h40, 4'h2, 4'hc);
        beat(32'h50, 4'hf, 4'hc);
        beat(32'h54, 4'hf, 4'hc);
        idle();
        wait_empty();
        for (int i = 0; i < 4; i++)
            got(b + i, i < 2 ? 32'h40 : 32'h48 + 4 * i, 0);
        chk(bus.log_be[b + 1], 4'h2);
        slow = '0;
        $display("no merge test done");
    endtask
    task automatic t_evict;
        int b;
        b = bus.count;
        hold = '1;
        buff = '0;
        cach = '1;
        for (int i = 0; i < 4; i++)
            beat(32'h300 + 4 * i, 4'hf, {i == 0, i == 3, 2'h1});
        idle();
        hold = '0;
        wait_empty();
        for (int i = 0; i < 4; i++)
            got(b + i, 32'h300 + 4 * i, i != 0);
        buff = '1;
        cach = '0;
        $display("eviction test done");
    endtask
    task automatic t_unbuf;
        int b;
        b = bus.count;
        hold = '1;
        beat(32'h60, 4'hf, 4'hc);
        idle();
        pu = '0;
        stuck(32'h64, 4'hc);
        idle();
        pu = '1;
        repeat (4) @(negedge clk);
        chk(bempty, 1);
        chk(bus.count - b, 1);
        $display("unbuffered test done");
    endtask
    task automatic t_drain;
        for (int k = 0; k < 2; k++) begin
            hold = '1;
            beat(32'h70, 4'hf, 4'hc);
            idle();
            if (k == 0)
                cp(4'h7, 4'ha, 3'h4, '0);
            else
                nc = '1;
            #1;
            chk(stall_c, 1);
            hold = '0;
            wait_empty();
            chk(stall_c, 0);
            nc = '0;
        end
        $display("drain test done");
    endtask
    task automatic t_lock;
        // lock run starts from a flushed cache, buffer idle
        cp(4'h9, 4'h0, 3'h0, 32'h0800_0000);
        for (int s = 0; s < 4; s++)
            fill(32'h1000 + 16 * s, 0, 0);
        cp(4'h9, 4'h0, 3'h0, 32'h0800_0001);
        fill(32'h2000, 1, 1);
        cp(4'h9, 4'h0, 3'h0, 32'h0000_0002);
        for (int j = 0; j < 70; j++)
            fill(32'h3000 + 16 * j, 2, 63);
        cp(4'h9, 4'h0, 3'h1, 32'h0800_0003);
        @(negedge clk);
        if_r = '1;
        #1;
        chk(iline, 3);
        @(negedge clk);
        if_r = '0;
        ce = '0;
        cp(4'h9, 4'h0, 3'h1, 32'h0800_0007);
        chk(iline, 3);
        ce = '1;
        cp(4'h7, 4'hd, 3'h1, 32'h2040);
        chk(ifv, 1);
        chk(ifa, 32'h2040);
        @(negedge clk);
        #1;
        chk(ifv, 0);
        $display("lockdown test done");
    endtask
    initial begin
        repeat (16) @(negedge clk);
        srst = '0;
        #1;
        t_reset();
        t_stm();
        t_merge();
        t_evict();
        t_unbuf();
        t_drain();
        t_lock();
        end_of_test();
    end
endmodule
`default_nettype wire
